// ===== hw/dcrc_map.svh
// Register offsets, field positions and reset values of the DMA CRC reorder unit.
// Assumes inclusion by bare name from the design module.
`ifndef DCRC_MAP_SVH
`define DCRC_MAP_SVH
`define DCRC_CTRL_OFFSET     32'h0000_0000
`define DCRC_CTRL_RESET      32'h0000_0000
`define DCRC_CTRL_MASK       32'h3900_1FE7
`define DCRC_RESULT_OFFSET   32'h0000_0004
`define DCRC_BYTE_ORDER_HI   29
`define DCRC_BYTE_ORDER_LO   28
`define DCRC_WRITE_REORD_BIT 27
`define DCRC_BIT_ORDER_BIT   24
`define DCRC_POLY_LENGTH_M1_HI         12
`define DCRC_POLY_LENGTH_M1_LO         8
`define DCRC_ENABLE_BIT      7
`define DCRC_APPEND_BIT      6
`define DCRC_MODE_BIT        5
`define DCRC_CHAN_HI         2
`define DCRC_CHAN_LO         0
`define DCRC_ADDR_W          4
`endif

// ===== hw/dcrc_pkg.sv
// Types of the DMA CRC reorder unit.
// Assumes the map header is on the include path.
package dcrc_pkg;
  typedef enum logic [1:0] {
    DCRC_ORD_NONE  = 2'h0,
    DCRC_ORD_WORD  = 2'h1,
    DCRC_ORD_HALF  = 2'h2,
    DCRC_ORD_BYTES = 2'h3
  } dcrc_order_e;
  typedef enum logic [2:0] {
    DCRC_RD_IDLE = 3'b001,
    DCRC_RD_RESP = 3'b010,
    DCRC_RD_SPARE = 3'b100
  } dcrc_rd_e;
endpackage : dcrc_pkg

// ===== hw/dcrc_unit.sv
// CRC and IP checksum engine with byte reordering in a DMA channel data path.
// Assumes one AXI4-Lite master and a DMA stream source and sink on REF_CLK.
// Function
// (RULE1) Order 00 feeds the engine source bytes unchanged.
// (RULE2) Order 01 reverses all four bytes of each word.
// (RULE3) Order 10 swaps half-words, keeping byte order within them.
// (RULE4) Order 11 swaps the bytes inside each half-word.
// (RULE5) Write-order set sends reordered data out, else the source data.
// (RULE6) Mode bit picks IP checksum when 1, LFSR CRC when 0.
// (RULE7) In IP mode bit-order 1 computes the checksum reflected.
// (RULE8) In LFSR mode bit-order 1 computes the CRC reflected.
// (RULE9) In LFSR mode the length field holds polynomial length minus one.
// (RULE10) In IP mode the length field is ignored.
// (RULE11) Enable routes the selected channel through the engine.
// (RULE12) Disabled, transfers pass unchanged and the engine is idle.
// (RULE13) With write-order set, append cannot be set; no unaligned transfers.
// (RULE14) Unimplemented control bits read as zero.
// (RULE15) All control fields reset to zero.
// (RULE16) Channel select chooses which DMA channel is routed through.
`timescale 1ns/1ps
`default_nettype none
`include "dcrc_map.svh"
module dcrc_unit
  import dcrc_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int DEPTH    = 2
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [2:0]  IN_CHANNEL,
  input  wire logic [31:0] IN_DATA,
  input  wire logic        IN_VALID,
  output logic             IN_READY,
  output logic [31:0]      OUT_DATA,
  output logic [2:0]       OUT_CHANNEL,
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  input  wire logic        CRC_CLEAR,
  output logic [31:0]      CRC_RESULT
);
  if (CHANNELS < 1 || CHANNELS > 8 || DEPTH != 2) begin : g_bad_params
    $error("dcrc_unit: unsupported CHANNELS or DEPTH");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    dcrc_rd_e    rd;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [DEPTH-1:0][31:0] buf_data;
    logic [DEPTH-1:0][2:0]  buf_chan;
    logic [1:0]  count;
    logic        wr_ptr;
    logic        rd_ptr;
    logic [31:0] crc;
  } dcrc_state_s;

  dcrc_state_s q, d;

  logic [1:0]  byte_order_sel;
  logic        write_reordered;
  logic        bit_order_sel;
  logic [4:0]  poly_length_m1;
  logic        engine_enable;
  logic        checksum_mode_sel;
  logic [2:0]  channel_select;
  logic [31:0] reordered;
  logic [31:0] poly;
  logic [31:0] crc_next;
  logic [31:0] top_mask;
  logic        route_hit;
  logic        push;
  logic        pop;

  assign byte_order_sel    = q.ctrl[`DCRC_BYTE_ORDER_HI:`DCRC_BYTE_ORDER_LO];
  assign write_reordered   = q.ctrl[`DCRC_WRITE_REORD_BIT];
  assign bit_order_sel     = q.ctrl[`DCRC_BIT_ORDER_BIT];
  assign poly_length_m1    = q.ctrl[`DCRC_POLY_LENGTH_M1_HI:`DCRC_POLY_LENGTH_M1_LO];
  assign engine_enable     = q.ctrl[`DCRC_ENABLE_BIT];
  assign checksum_mode_sel = q.ctrl[`DCRC_MODE_BIT];
  assign channel_select    = q.ctrl[`DCRC_CHAN_HI:`DCRC_CHAN_LO];

  // Polynomial taps are not in the control word, so a fixed generic set is used.
  assign poly = 32'h04C1_1DB7;

  always_comb begin
    case (dcrc_order_e'(byte_order_sel))
      DCRC_ORD_WORD:  reordered = {IN_DATA[7:0], IN_DATA[15:8], IN_DATA[23:16],
                                   IN_DATA[31:24]}; // [RULE2]
      DCRC_ORD_HALF:  reordered = {IN_DATA[15:0], IN_DATA[31:16]}; // [RULE3]
      DCRC_ORD_BYTES: reordered = {IN_DATA[23:16], IN_DATA[31:24], IN_DATA[7:0],
                                   IN_DATA[15:8]}; // [RULE4]
      default:        reordered = IN_DATA; // [RULE1]
    endcase
  end

  assign route_hit = engine_enable && (IN_CHANNEL == channel_select); // [RULE11] [RULE16]
  assign IN_READY  = (q.count != 2'h2);
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;

  // Engine runs on the reordered word; the bit order and mode pick the algorithm.
  always_comb begin
    logic [31:0] c;
    logic [31:0] din;
    logic [16:0] s;
    logic        fb;
    c = q.crc;
    din = bit_order_sel ? {<<{reordered}} : reordered; // [RULE7] [RULE8]
    top_mask = 32'hFFFF_FFFF >> (5'h1F - poly_length_m1); // [RULE9]
    s = 17'h0_0000;
    fb = 1'b0;
    if (checksum_mode_sel) begin // [RULE6] [RULE10]
      s = {1'b0, c[15:0]} + {1'b0, din[31:16]};
      s = {1'b0, s[15:0]} + {16'h0000, s[16]};
      s = {1'b0, s[15:0]} + {1'b0, din[15:0]};
      s = {1'b0, s[15:0]} + {16'h0000, s[16]};
      c = {16'h0000, s[15:0]};
    end else begin
      for (int i = 31; i >= 0; i--) begin
        fb = c[poly_length_m1] ^ din[i];
        c = ((c << 1) ^ (fb ? poly : 32'h0000_0000)) & top_mask;
      end
    end
    crc_next = c;
  end

  always_comb begin
    d = q;
    S_AXI_AWREADY = !q.aw_got && !q.bvalid;
    S_AXI_WREADY  = !q.w_got && !q.bvalid;
    S_AXI_ARREADY = (q.rd == DCRC_RD_IDLE);
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      d.aw_got  = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      d.w_got  = 1'b1;
      d.w_data = S_AXI_WDATA;
      d.w_strb = S_AXI_WSTRB;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      if ({28'h000_0000, q.aw_addr[3:2], 2'h0} == `DCRC_CTRL_OFFSET) begin
        d.bresp = 2'h0;
        for (int b = 0; b < 4; b++) begin
          if (q.w_strb[b]) begin
            d.ctrl[b*8 +: 8] = q.w_data[b*8 +: 8];
          end
        end
        d.ctrl = d.ctrl & `DCRC_CTRL_MASK; // [RULE14]
        if (d.ctrl[`DCRC_WRITE_REORD_BIT]) begin
          d.ctrl[`DCRC_APPEND_BIT] = 1'b0; // [RULE13]
        end
      end else begin
        d.bresp = 2'h2;
      end
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    case (q.rd)
      DCRC_RD_IDLE: begin
        if (S_AXI_ARVALID) begin
          d.rd = DCRC_RD_RESP;
          if ({28'h000_0000, S_AXI_ARADDR[3:2], 2'h0} == `DCRC_CTRL_OFFSET) begin
            d.rdata = q.ctrl;
            d.rresp = 2'h0;
          end else if ({28'h000_0000, S_AXI_ARADDR[3:2], 2'h0} == `DCRC_RESULT_OFFSET) begin
            d.rdata = q.crc;
            d.rresp = 2'h0;
          end else begin
            d.rdata = 32'h0000_0000;
            d.rresp = 2'h2;
          end
        end
      end
      DCRC_RD_RESP: begin
        if (S_AXI_RREADY) begin
          d.rd = DCRC_RD_IDLE;
        end
      end
      default: d.rd = DCRC_RD_IDLE;
    endcase
    if (push) begin
      d.buf_data[q.wr_ptr] = (route_hit && write_reordered) ? reordered : IN_DATA; // [RULE5] [RULE12]
      d.buf_chan[q.wr_ptr] = IN_CHANNEL;
      d.wr_ptr = !q.wr_ptr;
    end
    if (pop) begin
      d.rd_ptr = !q.rd_ptr;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
    if (CRC_CLEAR) begin
      d.crc = 32'h0000_0000;
    end else if (push && route_hit) begin
      d.crc = crc_next; // [RULE11]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0; // [RULE15]
      q.rd <= DCRC_RD_IDLE;
    end else begin
      q <= d;
    end
  end

  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP  = q.bresp;
  assign S_AXI_RVALID = (q.rd == DCRC_RD_RESP);
  assign S_AXI_RDATA  = q.rdata;
  assign S_AXI_RRESP  = q.rresp;
  assign OUT_VALID    = (q.count != 2'h0);
  assign OUT_DATA     = q.buf_data[q.rd_ptr];
  assign OUT_CHANNEL  = q.buf_chan[q.rd_ptr];
  assign CRC_RESULT   = q.crc;

  property p_append_blocked;
    @(posedge REF_CLK) disable iff (!RST_N)
      q.ctrl[`DCRC_WRITE_REORD_BIT] |-> !q.ctrl[`DCRC_APPEND_BIT];
  endproperty
  a_append_blocked: assert property (p_append_blocked) // [RULE13]
    else $error("append set while write-order set");

  property p_reserved_zero;
    @(posedge REF_CLK) disable iff (!RST_N)
      (q.ctrl & ~`DCRC_CTRL_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE14]
    else $error("reserved control bit set");

  property p_passthru;
    @(posedge REF_CLK) disable iff (!RST_N)
      (push && !route_hit && q.count == 2'h0) |=> OUT_DATA == $past(IN_DATA);
  endproperty
  a_passthru: assert property (p_passthru) // [RULE12]
    else $error("unrouted word altered");

  property p_word_swap;
    @(posedge REF_CLK) disable iff (!RST_N)
      (push && route_hit && write_reordered && byte_order_sel == 2'h1 && q.count == 2'h0)
      |=> OUT_DATA[7:0] == $past(IN_DATA[31:24]);
  endproperty
  a_word_swap: assert property (p_word_swap) // [RULE2]
    else $error("word byte reversal wrong");

  property p_half_swap;
    @(posedge REF_CLK) disable iff (!RST_N)
      (push && route_hit && write_reordered && byte_order_sel == 2'h2 && q.count == 2'h0)
      |=> OUT_DATA[15:0] == $past(IN_DATA[31:16]);
  endproperty
  a_half_swap: assert property (p_half_swap) // [RULE3]
    else $error("half-word swap wrong");

  property p_byte_swap;
    @(posedge REF_CLK) disable iff (!RST_N)
      (push && route_hit && write_reordered && byte_order_sel == 2'h3 && q.count == 2'h0)
      |=> OUT_DATA[31:24] == $past(IN_DATA[23:16]);
  endproperty
  a_byte_swap: assert property (p_byte_swap) // [RULE4]
    else $error("byte swap in half-word wrong");

  property p_no_reorder;
    @(posedge REF_CLK) disable iff (!RST_N)
      (push && !write_reordered && q.count == 2'h0) |=> OUT_DATA == $past(IN_DATA);
  endproperty
  a_no_reorder: assert property (p_no_reorder) // [RULE5]
    else $error("unreordered output altered");

  property p_crc_idle;
    @(posedge REF_CLK) disable iff (!RST_N)
      (!engine_enable && !CRC_CLEAR) |=> $stable(q.crc);
  endproperty
  a_crc_idle: assert property (p_crc_idle) // [RULE11]
    else $error("engine moved while disabled");

  property p_ip_width;
    @(posedge REF_CLK) disable iff (!RST_N)
      (push && route_hit && checksum_mode_sel) |=> q.crc[31:16] == 16'h0000;
  endproperty
  a_ip_width: assert property (p_ip_width) // [RULE6]
    else $error("checksum wider than 16 bits");
endmodule : dcrc_unit
`default_nettype wire

// ===== bench/dcrc_sink.sv
// DMA destination model that takes the words the unit sends out.
// Assumes the bench drives clk and stall; taken words queue in arrival order.
`timescale 1ns/1ps
`default_nettype none
module dcrc_sink (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic [2:0]  out_channel,
  output logic             out_ready
);
  logic [31:0] got[$];
  logic [2:0]  gc[$];
  logic        hit;
  logic [31:0] hd;
  logic [2:0]  hc;
  initial out_ready = 1'b0;
  // Sampled before the edge so the capture never races the unit's update.
  always @(negedge clk) begin
    hit = out_valid & out_ready;
    hd  = out_data;
    hc  = out_channel;
  end
  always @(posedge clk) begin
    if (hit) got.push_back(hd);
    if (hit) gc.push_back(hc);
    out_ready <= ~stall;
  end
endmodule : dcrc_sink
`default_nettype wire

// ===== bench/dcrc_unit_tb.sv
// Self-checking bench of the DMA CRC reorder unit.
// Assumes the unit and the destination model; register bus is AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dcrc_unit_tb;
  import dcrc_pkg::*;
  logic        clk, rst_n, awv, wv, bready, arv, rready, in_v, clr, stall;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, in_data, rd;
  logic [2:0]  in_ch;
  logic [1:0]  rsp;
  wire logic   awr, wr, bv, arr, rv, in_r, out_v, out_r;
  wire logic [1:0]  bresp, rresp;
  wire logic [2:0]  out_ch;
  wire logic [31:0] rdata, out_d, crc;
  int errors, compares;
  logic [2:0] sent[$];
  dcrc_unit dcrc_unit_inst (.REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .IN_CHANNEL(in_ch), .IN_DATA(in_data), .IN_VALID(in_v),
    .IN_READY(in_r), .OUT_DATA(out_d), .OUT_CHANNEL(out_ch), .OUT_VALID(out_v),
    .OUT_READY(out_r), .CRC_CLEAR(clr), .CRC_RESULT(crc));
  dcrc_sink dcrc_sink_inst (.clk(clk), .stall(stall), .out_valid(out_v),
    .out_data(out_d), .out_channel(out_ch), .out_ready(out_r));
  always #10 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Ready is sampled at the falling edge: inputs only move at rising edges.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    bh = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    while (!bh) begin
      @(negedge clk);
      ah = awv & awr; wh = wv & wr; bh = bv & bready; rsp = bresp;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    logic ah, rh;
    rh = 1'b0;
    @(posedge clk);
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    while (!rh) begin
      @(negedge clk);
      ah = arv & arr; rh = rv & rready; rd = rdata; rsp = rresp;
      @(posedge clk);
      if (ah) arv <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd
  // Only whole aligned words are offered.
  task automatic push(input logic [2:0] ch, input logic [31:0] d);
    logic h;
    h = 1'b0;
    @(posedge clk);
    in_ch <= ch; in_data <= d; in_v <= 1'b1;
    while (!h) begin
      @(negedge clk);
      h = in_r;
      @(posedge clk);
    end
    in_v <= 1'b0;
    sent.push_back(ch);
  endtask : push
  task automatic take(input logic [31:0] exp);
    logic [31:0] w;
    logic [2:0]  c;
    logic [2:0]  ec;
    repeat (40) if (dcrc_sink_inst.got.size() == 0) @(posedge clk);
    w = (dcrc_sink_inst.got.size() > 0) ? dcrc_sink_inst.got.pop_front() : 32'hX;
    c = (dcrc_sink_inst.gc.size() > 0) ? dcrc_sink_inst.gc.pop_front() : 3'hX;
    ec = (sent.size() > 0) ? sent.pop_front() : 3'h0;
    check(w, exp);
    check({29'h0, c}, {29'h0, ec});
  endtask : take
  function automatic logic [31:0] crc_msb(input logic [31:0] d, input int len);
    logic [31:0] c, p, m;
    m = (len == 32) ? 32'hFFFF_FFFF : (32'h1 << len) - 32'h1;
    p = 32'h04C1_1DB7 & m;
    c = 32'h0;
    for (int i = 31; i >= 0; i--) c = ((c << 1) ^ ((c[len-1] ^ d[i]) ? p : 32'h0)) & m;
    return c;
  endfunction : crc_msb
  task automatic t_regs;
    axi_rd(4'h0); check(rd, 32'h0);
    axi_wr(4'h0, 32'hFFFF_FFFF); axi_rd(4'h0); check(rd, 32'h3900_1FA7);
    axi_wr(4'h0, 32'h0000_0040); axi_rd(4'h0); check(rd, 32'h0000_0040);
    axi_wr(4'h8, 32'h1); check({30'h0, rsp}, 32'h2);
    axi_rd(4'hC); check({30'h0, rsp}, 32'h2);
  endtask : t_regs
  task automatic t_order;
    logic [31:0] exp [4];
    logic [31:0] c0;
    exp = '{32'h1122_3344, 32'h4433_2211, 32'h3344_1122, 32'h2211_4433};
    for (int o = 0; o < 4; o++) begin
      axi_wr(4'h0, (o << 28) | 32'h0800_0083); push(3'h3, 32'h1122_3344);
      take(exp[o]);
    end
    push(3'h2, 32'h1122_3344); take(32'h1122_3344);
    axi_wr(4'h0, 32'h1000_0083); push(3'h3, 32'h1122_3344); take(32'h1122_3344);
    axi_wr(4'h0, 32'h1800_0003); axi_rd(4'h4); c0 = rd;
    push(3'h3, 32'h1122_3344); take(32'h1122_3344);
    axi_rd(4'h4); check(rd, c0);
  endtask : t_order
  // The destination stalls, so the two-entry buffer must refuse a third word.
  task automatic t_fill;
    stall <= 1'b1; repeat (2) @(posedge clk);
    push(3'h0, 32'hAAAA_0001); push(3'h0, 32'hAAAA_0002);
    @(posedge clk); in_data <= 32'hAAAA_0003; in_v <= 1'b1;
    @(negedge clk); check({31'h0, in_r}, 32'h0);
    @(posedge clk); in_v <= 1'b0; stall <= 1'b0;
    take(32'hAAAA_0001); take(32'hAAAA_0002);
  endtask : t_fill
  // The reflected LFSR cases feed the bit-reversed word to a plain MSb-first model.
  task automatic t_crc;
    logic [31:0] e;
    for (int l = 0; l < 3; l++) begin
      axi_wr(4'h0, ((l % 2) * 31 << 8) | ((l / 2) << 24) | 32'hA0);
      clr <= 1'b1; @(posedge clk); clr <= 1'b0;
      push(3'h0, 32'h1234_5678); take(32'h1234_5678);
      e = (l == 2) ? 32'h0000_4AB2 : 32'h0000_68AC;
      axi_rd(4'h4); check(rd, e);
      check(crc, e);
    end
    for (int l = 16; l <= 32; l += 16) begin
      for (int b = 0; b < 2; b++) begin
        axi_wr(4'h0, ((l - 1) << 8) | (b << 24) | 32'h80);
        clr <= 1'b1; @(posedge clk); clr <= 1'b0;
        push(3'h0, 32'hA5A5_0F0F); take(32'hA5A5_0F0F);
        e = crc_msb((b == 1) ? 32'hF0F0_A5A5 : 32'hA5A5_0F0F, l);
        axi_rd(4'h4); check(rd, e);
        check(crc, e);
      end
    end
  endtask : t_crc
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test;
  end
  initial begin
    clk = 1'b0; rst_n = 1'b0; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0;
    rready = 1'b0; in_v = 1'b0; clr = 1'b0; stall = 1'b0; awaddr = 4'h0; araddr = 4'h0;
    wstrb = 4'hF; wdata = 32'h0; in_data = 32'h0; in_ch = 3'h0; errors = 0; compares = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_order;
    t_fill;
    t_crc;
    end_of_test;
  end
endmodule : dcrc_unit_tb
`default_nettype wire
